// File: scan_timer_pkg.sv
// package: constants, types and carriers for the scan timer bank
package scan_timer_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned TICK_1MS_US = 1000;
	localparam int unsigned CYC_PER_1MS = CLK_HZ / 1000000 * TICK_1MS_US;
	localparam int unsigned DIV_10 = 10;
	localparam int unsigned NUM_TIMERS = 256;
	localparam int unsigned IDX_W = 8;
	localparam int unsigned CNT_W = 16;
	localparam logic [15:0] CNT_MAX = 16'h7FFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [7:0] RET_LO_END = 8'h1F;
	localparam logic [7:0] RET_HI_BEG = 8'h40;
	localparam logic [7:0] RET_HI_END = 8'h5F;
	localparam logic [7:0] SEG_LO_BEG = 8'h00;
	localparam logic [7:0] SEG_HI_BEG = 8'h20;
	localparam logic [7:0] HI_BLOCK_BEG = 8'h40;
	localparam logic [7:0] HI_BLOCK_END = 8'h64;
	localparam logic [7:0] OFS_10_LO = 8'h01;
	localparam logic [7:0] OFS_10_HI = 8'h04;

	typedef enum logic [1:0] {
		RES_1MS = 2'h0,
		RES_10MS = 2'h1,
		RES_100MS = 2'h2
	} res_t;

	// operation kind issued by the scan engine
	typedef enum logic [2:0] {
		OP_PLAIN_ON = 3'h1,
		OP_ACCUM_ON = 3'h2,
		OP_OFF_DELAY = 3'h4
	} op_kind_t;

	// one operation request from the scan engine
	typedef struct packed {
		logic valid;
		logic reset;
		logic enable;
		logic step_active;
		op_kind_t kind;
		logic [7:0] index;
		logic [15:0] preset_time;
	} timer_op_t;

	// one answer per executed operation
	typedef struct packed {
		logic valid;
		logic [7:0] index;
		logic timer_bit;
		logic [15:0] current;
	} timer_ans_t;

	typedef struct packed {
		logic [15:0] current;
		logic timer_bit;
		logic last_en;
		logic armed;
		logic is_off;
		logic [15:0] preset;
		logic [15:0] pending;
	} timer_rec_t;

	typedef struct packed {
		logic [15:0] div_1ms;
		logic [3:0] div_10;
		logic [3:0] div_100;
		logic t1;
		logic t10;
		logic t100;
	} tick_state_t;
endpackage

// File: tick_gen.sv
// free-running prescaler giving 1, 10 and 100 ms one-cycle ticks
`timescale 1ns/1ns
module tick_gen #(
	parameter int unsigned CYC_1MS = scan_timer_pkg::CYC_PER_1MS
) (
	input wire logic i_clk, // system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_ce, // clock enable
	output logic o_t1, // 1 ms tick
	output logic o_t10, // 10 ms tick
	output logic o_t100 // 100 ms tick
);
	import scan_timer_pkg::*;
	tick_state_t st_r;
	tick_state_t st_nxt;
	logic wrap1;

	// cascade of dividers so the three ticks share edges [RQ23]
	always_comb begin
		st_nxt = st_r;
		wrap1 = (st_r.div_1ms == 16'(CYC_1MS - 1));
		st_nxt.t1 = wrap1;
		st_nxt.t10 = 1'b0;
		st_nxt.t100 = 1'b0;
		if (wrap1) begin
			st_nxt.div_1ms = 16'h0000;
			if (st_r.div_10 == 4'(DIV_10 - 1)) begin
				st_nxt.div_10 = 4'h0;
				st_nxt.t10 = 1'b1;
				if (st_r.div_100 == 4'(DIV_10 - 1)) begin
					st_nxt.div_100 = 4'h0;
					st_nxt.t100 = 1'b1;
				end else begin
					st_nxt.div_100 = st_r.div_100 + 4'h1;
				end
			end else begin
				st_nxt.div_10 = st_r.div_10 + 4'h1;
			end
		end else begin
			st_nxt.div_1ms = st_r.div_1ms + 16'h0001;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_t1 = st_r.t1;
	assign o_t10 = st_r.t10;
	assign o_t100 = st_r.t100;

	property p_tick_width;
		@(posedge i_clk) disable iff (!i_rst_n) (i_ce && st_r.t10) |=> !st_r.t10;
	endproperty
	a_tick_width: assert property (p_tick_width) else $error("tick wider than one cycle"); // [RQ23]
endmodule

// File: scan_timer_bank.sv
// bank of 256 scan-driven timers with per-index class and resolution
`timescale 1ns/1ns
// Operation
// RQ1: on-delay types accumulate while enabled; bit on when count reaches preset.
// RQ2: on-delay counts saturate at 32767, never wrap.
// RQ3: plain on-delay with enable off: count zero, bit off.
// RQ4: accumulating on-delay holds count and bit while disabled.
// RQ5: accumulating on-delay clears only by reset command.
// RQ6: reset command: bit off, count zero, any type.
// RQ7: off-delay enabled: bit on at once, count zero.
// RQ8: off-delay after fall counts to preset, then bit off, holds.
// RQ9: off-delay re-enabled before preset keeps bit on.
// RQ10: off-delay starts only on detected on-to-off edge.
// RQ11: after reset, off-delay waits for a fresh falling edge.
// RQ12: inactive step region forces off-delay to zero, bit off.
// RQ13: power-up: all bits off, counts zero, retention optional.
// RQ14: indices 0 to 255 exist with fixed class and resolution.
// RQ15: accumulating class resolutions by index.
// RQ16: plain class resolutions by index.
// RQ17: one count equals one time-base interval.
// RQ18: 1 ms timers update on every tick, independent of scan.
// RQ19: 10 ms timers add pending ticks at scan start.
// RQ20: 100 ms timers update on execution; engine executes once per scan.
// RQ21: engine never shares an index between on- and off-delay.
// RQ22: engine adds one to preset for a minimum interval.
// RQ23: prescaler makes one-cycle 1, 10, 100 ms ticks.
module scan_timer_bank #(
	parameter int unsigned CYC_1MS = scan_timer_pkg::CYC_PER_1MS,
	parameter bit RETAIN_ACCUM = 1'b0
) (
	input wire logic i_clk, // system clock, 20 MHz
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_ce, // clock enable, freezes all state
	input wire logic i_scan_start, // pulse: start of a scan
	input wire logic i_first_scan, // pulse: first scan, clears state
	input wire scan_timer_pkg::timer_op_t i_op, // operation request
	output scan_timer_pkg::timer_ans_t o_ans, // registered answer
	output logic [255:0] o_timer_bits // all timer bits, registered
);
	import scan_timer_pkg::*;

	typedef struct packed {
		timer_ans_t ans;
		logic [255:0] bits;
	} bank_state_t;

	timer_rec_t mem [NUM_TIMERS];
	bank_state_t st_r;
	bank_state_t st_nxt;
	logic t1, t10, t100;
	logic [255:0] bits_live;

	tick_gen #(.CYC_1MS(CYC_1MS)) u_tick (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.o_t1(t1),
		.o_t10(t10),
		.o_t100(t100)
	);

	// fixed class per index [RQ14] [RQ15] [RQ16]
	function automatic logic is_retentive(input logic [7:0] idx);
		return (idx <= RET_LO_END) || (idx >= RET_HI_BEG && idx <= RET_HI_END);
	endfunction

	function automatic res_t res_of(input logic [7:0] idx);
		logic [7:0] off;
		off = 8'h00;
		if (idx > HI_BLOCK_END) begin
			return RES_100MS;
		end
		off = (idx >= HI_BLOCK_BEG) ? (idx - HI_BLOCK_BEG) : idx;
		off = (off >= SEG_HI_BEG) ? (off - SEG_HI_BEG) : (off - SEG_LO_BEG);
		if (off == 8'h00) begin
			return RES_1MS;
		end
		if (off >= OFS_10_LO && off <= OFS_10_HI) begin
			return RES_10MS;
		end
		return RES_100MS;
	endfunction

	// advance one record by n intervals; shared by ticks and executions [RQ17]
	function automatic timer_rec_t advance(input timer_rec_t r, input logic [15:0] n);
		timer_rec_t o;
		logic [16:0] sum;
		o = r;
		sum = 17'h00000;
		if (r.is_off) begin
			if (r.armed) begin
				sum = {1'b0, r.current} + {1'b0, n};
				if (sum >= {1'b0, r.preset}) begin // [RQ8]
					o.current = r.preset;
					o.timer_bit = 1'b0;
					o.armed = 1'b0;
				end else begin
					o.current = sum[15:0];
				end
			end
		end else if (r.last_en) begin
			sum = {1'b0, r.current} + {1'b0, n};
			o.current = (sum > {1'b0, CNT_MAX}) ? CNT_MAX : sum[15:0]; // [RQ2]
			o.timer_bit = (o.current >= r.preset); // [RQ1]
		end
		return o;
	endfunction

	// apply an executed operation to a record
	function automatic timer_rec_t execute(input timer_rec_t r, input timer_op_t op,
			input logic [15:0] n);
		timer_rec_t o;
		o = r;
		o.preset = op.preset_time;
		o.is_off = (op.kind == OP_OFF_DELAY);
		if (op.reset) begin // [RQ5] [RQ6] [RQ11]
			o.current = CNT_ZERO;
			o.timer_bit = 1'b0;
			o.armed = 1'b0;
			o.last_en = 1'b0;
			o.pending = CNT_ZERO;
		end else if (op.kind == OP_OFF_DELAY) begin
			if (!op.step_active) begin // [RQ12]
				o.current = CNT_ZERO;
				o.timer_bit = 1'b0;
				o.armed = 1'b0;
				o.last_en = 1'b0;
			end else if (op.enable) begin // [RQ7] [RQ9]
				o.current = CNT_ZERO;
				o.timer_bit = 1'b1;
				o.armed = 1'b0;
				o.last_en = 1'b1;
			end else begin
				o.armed = r.armed | r.last_en; // [RQ10]
				o.last_en = 1'b0;
				o = advance(o, n);
			end
		end else begin
			o.last_en = op.enable;
			if (op.enable) begin
				o = advance(o, n); // [RQ1]
				o.timer_bit = (o.current >= o.preset);
			end else if (op.kind == OP_PLAIN_ON) begin // [RQ3]
				o.current = CNT_ZERO;
				o.timer_bit = 1'b0;
			end // accumulating: hold [RQ4]
		end
		return o;
	endfunction

	timer_rec_t cur;
	timer_rec_t nxt_rec;
	res_t op_res;
	logic [15:0] op_n;

	// build next answer and bit vector for the executed operation [RQ20]
	always_comb begin
		st_nxt = st_r;
		st_nxt.ans.valid = 1'b0;
		st_nxt.bits = bits_live; // bit vector lags the stored record by one cycle
		cur = mem[i_op.index];
		op_res = res_of(i_op.index);
		op_n = (op_res == RES_100MS) ? cur.pending : CNT_ZERO;
		nxt_rec = execute(cur, i_op, op_n);
		if (op_res == RES_100MS && !i_op.reset) begin
			nxt_rec.pending = CNT_ZERO;
		end
		if (i_op.valid) begin
			st_nxt.ans.valid = 1'b1;
			st_nxt.ans.index = i_op.index;
			st_nxt.ans.timer_bit = nxt_rec.timer_bit;
			st_nxt.ans.current = nxt_rec.current;
		end
		if (i_first_scan) begin
			st_nxt.bits = '0; // [RQ13]
			st_nxt.ans.valid = 1'b0;
		end
	end

	// per-timer tick handling; a tick in the same cycle is applied on top of the executed record [RQ18] [RQ19]
	genvar g;
	generate
		for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
			localparam res_t RES = res_of(8'(g));
			localparam logic RET = is_retentive(8'(g));
			logic hit;
			timer_rec_t r;
			assign hit = i_op.valid && (i_op.index == 8'(g));
			always_comb begin
				r = mem[g];
				if (hit) begin
					r = nxt_rec;
				end
				if (RES == RES_1MS && t1) begin
					r = advance(r, 16'h0001); // [RQ18]
				end
				if (RES == RES_10MS) begin
					if (i_scan_start) begin
						r = advance(r, r.pending); // [RQ19]
						r.pending = t10 ? 16'h0001 : CNT_ZERO;
					end else if (t10 && r.pending != CNT_MAX) begin
						r.pending = r.pending + 16'h0001;
					end
				end
				if (RES == RES_100MS && t100 && r.pending != CNT_MAX) begin
					r.pending = r.pending + 16'h0001; // [RQ20]
				end
				if (i_first_scan) begin // [RQ13]
					r.timer_bit = 1'b0;
					r.armed = 1'b0;
					r.last_en = 1'b0;
					r.pending = CNT_ZERO;
					if (!(RET && RETAIN_ACCUM)) begin
						r.current = CNT_ZERO;
					end
				end
			end
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					mem[g] <= '0;
				end else if (i_ce) begin
					mem[g] <= r;
				end
			end
		end
	endgenerate

	generate
		for (g = 0; g < NUM_TIMERS; g++) begin : g_bits
			assign bits_live[g] = mem[g].timer_bit;
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_ans = st_r.ans;
	assign o_timer_bits = st_r.bits;

	sequence s_plain_off;
		i_ce && !i_first_scan && i_op.valid && !i_op.reset && i_op.kind == OP_PLAIN_ON
			&& !i_op.enable;
	endsequence
	sequence s_reset_op;
		i_ce && !i_first_scan && i_op.valid && i_op.reset;
	endsequence

	property p_plain_off;
		@(posedge i_clk) disable iff (!i_rst_n)
			s_plain_off |=> (o_ans.current == 16'h0000 && !o_ans.timer_bit);
	endproperty
	a_plain_off: assert property (p_plain_off) else $error("plain timer not cleared"); // [RQ3]

	property p_reset;
		@(posedge i_clk) disable iff (!i_rst_n)
			s_reset_op |=> (o_ans.current == 16'h0000 && !o_ans.timer_bit);
	endproperty
	a_reset: assert property (p_reset) else $error("reset did not clear timer"); // [RQ6]

	property p_off_en;
		@(posedge i_clk) disable iff (!i_rst_n)
			(i_ce && !i_first_scan && i_op.valid && !i_op.reset && i_op.kind == OP_OFF_DELAY
				&& i_op.enable && i_op.step_active)
			|=> (o_ans.timer_bit && o_ans.current == 16'h0000);
	endproperty
	a_off_en: assert property (p_off_en) else $error("off-delay not on when enabled"); // [RQ7]

	property p_sat;
		@(posedge i_clk) disable iff (!i_rst_n)
			o_ans.valid |-> (o_ans.current <= 16'h7FFF);
	endproperty
	a_sat: assert property (p_sat) else $error("count above saturation"); // [RQ2]

	property p_step;
		@(posedge i_clk) disable iff (!i_rst_n)
			(i_ce && !i_first_scan && i_op.valid && i_op.kind == OP_OFF_DELAY
				&& !i_op.step_active)
			|=> (!o_ans.timer_bit && o_ans.current == 16'h0000);
	endproperty
	a_step: assert property (p_step) else $error("inactive step not forced"); // [RQ12]

	property p_on_bit;
		@(posedge i_clk) disable iff (!i_rst_n)
			(i_ce && !i_first_scan && i_op.valid && !i_op.reset
				&& i_op.kind != OP_OFF_DELAY && i_op.enable)
			|=> (o_ans.timer_bit == (o_ans.current >= $past(i_op.preset_time)));
	endproperty
	a_on_bit: assert property (p_on_bit) else $error("on-delay bit wrong"); // [RQ1]

	property p_first;
		@(posedge i_clk) disable iff (!i_rst_n)
			(i_ce && i_first_scan) |=> (o_timer_bits == '0);
	endproperty
	a_first: assert property (p_first) else $error("bits not off at first scan"); // [RQ13]

	property p_off_fin;
		@(posedge i_clk) disable iff (!i_rst_n)
			(o_ans.valid && o_ans.index >= 8'h20 && !o_ans.timer_bit && $past(i_op.kind) ==
				OP_OFF_DELAY && $past(i_op.step_active) && !$past(i_op.reset))
			|-> (o_ans.current == $past(i_op.preset_time) || o_ans.current == 16'h0000);
	endproperty
	a_off_fin: assert property (p_off_fin) else $error("off-delay ended off preset"); // [RQ8]
endmodule

// File: scan_engine_model.sv
// scan engine model: scan start pulses and one timer operation per scan
`timescale 1ns/1ns
module scan_engine_model #(
	parameter int unsigned SCAN_CYC = 200
) (
	input wire logic i_clk, // system clock
	output logic o_scan_start, // one-cycle scan start
	output logic o_first_scan, // one-cycle first scan
	output scan_timer_pkg::timer_op_t o_op // operation request
);
	import scan_timer_pkg::*;
	// idle at time zero so nothing is taken before the first scan
	initial begin
		o_scan_start = 1'h0;
		o_first_scan = 1'h0;
		o_op = '0;
	end
	// fixed scan length gives each 100 ms timer one tick per execution
	task automatic run_scan(input logic first, input timer_op_t op);
		@(posedge i_clk);
		o_scan_start <= 1'h1;
		o_first_scan <= first;
		@(posedge i_clk);
		o_scan_start <= 1'h0;
		o_first_scan <= 1'h0;
		o_op <= op; // executed once per scan
		@(posedge i_clk);
		o_op <= '0;
		repeat (SCAN_CYC - 3) @(posedge i_clk);
	endtask
endmodule

// File: testbench.sv
// self-checking bench for the scan timer bank
`timescale 1ns/1ns
module testbench;
	import scan_timer_pkg::*;
	localparam int unsigned CYC = 2;
	localparam int LIMIT = 90000;
	logic i_clk = 1'h0;
	logic i_rst_n = 1'h0;
	logic i_ce = 1'h1;
	logic scan_start;
	logic first_scan;
	timer_op_t op;
	timer_ans_t ans;
	logic [255:0] bits;
	logic [24:0] expq[$];
	logic [24:0] exp_v;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	int p;

	// 20 MHz clock
	always #25 i_clk = ~i_clk;

	scan_timer_bank #(.CYC_1MS(CYC), .RETAIN_ACCUM(1'h0)) dut_u (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_scan_start(scan_start),
		.i_first_scan(first_scan), .i_op(op), .o_ans(ans), .o_timer_bits(bits));

	scan_engine_model #(.SCAN_CYC(CYC * 100)) eng_u (
		.i_clk(i_clk), .o_scan_start(scan_start), .o_first_scan(first_scan), .o_op(op));

	task automatic check(input logic [24:0] seen, input logic [24:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checked %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// note the expected answer, then let the engine run one scan with the op
	task automatic do_op(input op_kind_t k, input logic [7:0] idx, input logic en,
		input logic rst, input logic step, input logic [15:0] pre, input logic eb,
		input logic [15:0] ec);
		timer_op_t o;
		o = '{valid: 1'h1, reset: rst, enable: en, step_active: step, kind: k, index: idx,
			preset_time: pre};
		expq.push_back({idx, eb, ec});
		eng_u.run_scan(1'h0, o);
	endtask

	// watcher: oldest note per answer, sampled mid-cycle where the answer has settled
	always @(negedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles >= LIMIT) begin
			n_mismatch++;
			end_of_test();
		end else if (ans.valid === 1'h1) begin
			exp_v = (expq.size() > 0) ? expq.pop_front() : 'x;
			check({ans.index, ans.timer_bit, ans.current}, exp_v);
		end
	end

	// distinct indices per timer type keep on- and off-delay apart
	initial begin
		void'($urandom(69642));
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'h1;
		@(posedge i_clk);
		check({24'h0, |bits}, 25'h0);
		eng_u.run_scan(1'h1, '0);
		// plain on-delay, random preset, 100 ms base
		p = $urandom_range(4, 2); // preset one above a nominal of 1 to 3
		do_op(OP_PLAIN_ON, 8'h25, 1'h0, 1'h0, 1'h1, p[15:0], 1'h0, 16'h0);
		for (int i = 1; i <= 5; i++) begin
			do_op(OP_PLAIN_ON, 8'h25, 1'h1, 1'h0, 1'h1, p[15:0], i >= p, i[15:0]);
		end
		do_op(OP_PLAIN_ON, 8'h25, 1'h0, 1'h0, 1'h1, p[15:0], 1'h0, 16'h0);
		$display("test plain on-delay done");
		// accumulating on-delay keeps time across off periods
		do_op(OP_ACCUM_ON, 8'h05, 1'h0, 1'h0, 1'h1, 16'h2, 1'h0, 16'h0);
		do_op(OP_ACCUM_ON, 8'h05, 1'h1, 1'h0, 1'h1, 16'h2, 1'h0, 16'h1);
		do_op(OP_ACCUM_ON, 8'h05, 1'h1, 1'h0, 1'h1, 16'h2, 1'h1, 16'h2);
		do_op(OP_ACCUM_ON, 8'h05, 1'h0, 1'h0, 1'h1, 16'h2, 1'h1, 16'h2);
		do_op(OP_ACCUM_ON, 8'h05, 1'h0, 1'h0, 1'h1, 16'h2, 1'h1, 16'h2);
		do_op(OP_ACCUM_ON, 8'h05, 1'h1, 1'h0, 1'h1, 16'h2, 1'h1, 16'h3);
		do_op(OP_ACCUM_ON, 8'h05, 1'h0, 1'h1, 1'h1, 16'h2, 1'h0, 16'h0);
		$display("test accumulating on-delay done");
		// off-delay: hold on, re-enable early, expire, reset, no fresh edge
		do_op(OP_OFF_DELAY, 8'h28, 1'h1, 1'h0, 1'h1, 16'h2, 1'h1, 16'h0);
		do_op(OP_OFF_DELAY, 8'h28, 1'h0, 1'h0, 1'h1, 16'h2, 1'h1, 16'h1);
		do_op(OP_OFF_DELAY, 8'h28, 1'h1, 1'h0, 1'h1, 16'h2, 1'h1, 16'h0);
		do_op(OP_OFF_DELAY, 8'h28, 1'h0, 1'h0, 1'h1, 16'h2, 1'h1, 16'h1);
		do_op(OP_OFF_DELAY, 8'h28, 1'h0, 1'h0, 1'h1, 16'h2, 1'h0, 16'h2);
		do_op(OP_OFF_DELAY, 8'h28, 1'h0, 1'h0, 1'h1, 16'h2, 1'h0, 16'h2);
		do_op(OP_OFF_DELAY, 8'h28, 1'h0, 1'h1, 1'h1, 16'h2, 1'h0, 16'h0);
		do_op(OP_OFF_DELAY, 8'h28, 1'h0, 1'h0, 1'h1, 16'h2, 1'h0, 16'h0);
		// off-delay merely low, then inactive step region
		do_op(OP_OFF_DELAY, 8'h29, 1'h0, 1'h0, 1'h1, 16'h5, 1'h0, 16'h0);
		do_op(OP_OFF_DELAY, 8'h29, 1'h1, 1'h0, 1'h1, 16'h5, 1'h1, 16'h0);
		do_op(OP_OFF_DELAY, 8'h29, 1'h0, 1'h0, 1'h1, 16'h5, 1'h1, 16'h1);
		do_op(OP_OFF_DELAY, 8'h29, 1'h0, 1'h0, 1'h0, 16'h5, 1'h0, 16'h0);
		$display("test off-delay done");
		// 10 ms timer: ten ticks per scan, added only at each scan start
		do_op(OP_PLAIN_ON, 8'h21, 1'h1, 1'h0, 1'h1, 16'hF, 1'h0, 16'h0);
		do_op(OP_PLAIN_ON, 8'h21, 1'h1, 1'h0, 1'h1, 16'hF, 1'h0, 16'hA);
		do_op(OP_PLAIN_ON, 8'h21, 1'h1, 1'h0, 1'h1, 16'hF, 1'h1, 16'h14);
		do_op(OP_PLAIN_ON, 8'h21, 1'h0, 1'h0, 1'h1, 16'hF, 1'h0, 16'h0);
		$display("test 10 ms scan update done");
		// 1 ms timer runs between executions until it saturates
		p = $urandom_range(1000, 1);
		do_op(OP_PLAIN_ON, 8'h20, 1'h1, 1'h0, 1'h1, p[15:0], 1'h0, 16'h0);
		repeat (66000) @(posedge i_clk);
		do_op(OP_PLAIN_ON, 8'h20, 1'h1, 1'h0, 1'h1, p[15:0], 1'h1, 16'h7FFF);
		check({22'h0, bits[32], bits[40], bits[41]}, 25'h4);
		do_op(OP_PLAIN_ON, 8'h20, 1'h0, 1'h0, 1'h1, p[15:0], 1'h0, 16'h0);
		$display("test saturation done");
		// first scan clears a set timer bit and a non-retained count
		// an idle execution first drops the ticks banked while the timer was not run
		do_op(OP_ACCUM_ON, 8'h05, 1'h0, 1'h0, 1'h1, 16'h1, 1'h0, 16'h0);
		do_op(OP_ACCUM_ON, 8'h05, 1'h1, 1'h0, 1'h1, 16'h1, 1'h1, 16'h1);
		eng_u.run_scan(1'h1, '0);
		check({24'h0, |bits}, 25'h0);
		do_op(OP_ACCUM_ON, 8'h05, 1'h0, 1'h0, 1'h1, 16'h1, 1'h0, 16'h0);
		$display("test first scan done");
		check(25'(expq.size()), 25'h0);
		end_of_test();
	end
endmodule
